// >>> common/amxd_cfg_if.sv
/*
  Carries synchronised serial pins to the word capture and the word back.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface amxd_cfg_if;
  import amxd_pkg::*;
  logic sclk_s;
  logic din_s;
  logic cnv_s;
  logic [CFG_W-1:0] word;
  logic word_valid;
  modport shifter (input sclk_s, input din_s, input cnv_s, output word, output word_valid);
  modport core (output sclk_s, output din_s, output cnv_s, input word, input word_valid);
endinterface : amxd_cfg_if

// >>> common/amxd_pkg.sv
/*
  Shared constants and types of the input mux configuration decoder.
  Assumes a single 250 MHz clock domain for all users.
*/
package amxd_pkg;
  // Configuration word layout
  localparam int CFG_W = 14;
  localparam int INCC_MSB = 12;
  localparam int INCC_LSB = 10;
  localparam int CHSEL_MSB = 9;
  localparam int CHSEL_LSB = 7;
  localparam int BW_BIT = 6;
  localparam logic [2:0] INCC_SE = 3'h7;
  localparam logic [2:0] INCC_COM_UNI = 3'h6;
  localparam logic [2:0] INCC_COM_BIP = 3'h2;
  localparam logic BW_FULL = 1'h1;
  localparam logic [13:0] CFG_RST = 14'h1C40;
  // Register offsets and fields
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_CFG = 4'h4;
  localparam logic [3:0] REG_STAT = 4'h8;
  localparam int CTL_SEQ_EN = 0;
  localparam int CTL_LAST_LSB = 1;
  localparam logic [3:0] CTRL_RST = 4'hE;
  localparam int ST_POS_LSB = 0;
  localparam int ST_NEG_LSB = 3;
  localparam int ST_SRC_LSB = 6;
  localparam int ST_TWOS = 8;
  localparam int ST_QBW = 9;
  localparam int ST_RATE = 10;
  // Timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int FULL_CONV_NS = 4000;
  localparam int QBW_DIV = 4;
  localparam int FULL_CYC = (FULL_CONV_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int QBW_CYC = FULL_CYC * QBW_DIV;
  localparam int GAP_W = 12;
  typedef enum logic [1:0] {NEG_GND, NEG_COM, NEG_PAIR} amxd_neg_t;
endpackage : amxd_pkg

// >>> rtl/amxd_cfg_shift.sv
/*
  Captures the configuration word, MSB first, on serial clock rises.
  Assumes synchronised pins; a frame runs while convert_start is low.
*/
`timescale 1ns/1ps
module amxd_cfg_shift
  import amxd_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Pins and captured word
  amxd_cfg_if.shifter cfg
);
  logic sclk_d_r;
  logic [3:0] cnt_r;
  logic [CFG_W-2:0] sh_r;
  wire sclk_rise = cfg.sclk_s & ~sclk_d_r;
  wire take = sclk_rise & ~cfg.cnv_s & (cnt_r < 4'(CFG_W));
  wire last = take & (cnt_r == 4'(CFG_W - 1));

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      sclk_d_r <= 1'h0;
      cnt_r <= 4'h0;
      sh_r <= '0;
      cfg.word <= CFG_RST;
      cfg.word_valid <= 1'h0;
    end
    else
    begin
      sclk_d_r <= cfg.sclk_s;
      cfg.word_valid <= last;
      if (cfg.cnv_s)
        cnt_r <= 4'h0;
      else if (take)
        cnt_r <= cnt_r + 4'h1;
      if (take)
        sh_r <= {sh_r[CFG_W-3:0], cfg.din_s};
      // First 14 rises only
      if (last)
        cfg.word <= {sh_r, cfg.din_s};
    end
  end
endmodule : amxd_cfg_shift

// >>> rtl/amxd_decode.sv
/*
  Input mux configuration decoder: serial word capture, sequencer,
  per-conversion routing, coding and bandwidth outputs, register port.
  Assumes serial and convert pins are asynchronous; register port is
  on clock, read data valid the cycle after the read strobe.
*/
// The implementer's own choices: the placing of the registers and the plain strobed port.
// What this block does
// - Input configuration 111 routes every input single-ended against ground.
// - Input configuration 010 measures each input against common as a mid-reference.
// - Input configuration 110 measures each input against common as a ground sense.
// - Configurations 00X convert bipolar pairs with a mid-reference negative member.
// - Configurations 10X convert unipolar pairs with a ground-sense negative member.
// - In pair modes with the sequencer off, even channel select makes the even input positive, odd the odd.
// - With the sequencer off, channel select names the positive input directly; in pair modes its partner is negative.
// - With the sequencer running in pair modes the positive input is always even.
// - The filter bit chooses full or quarter input bandwidth.
// - Bipolar configurations give twos complement results.
// - Unipolar configurations give straight binary results.
// - A rising convert_start ends acquisition and starts the conversion phase.
// - The 14-bit word is taken on the first 14 serial clock rises of a frame.
`timescale 1ns/1ps
module amxd_decode
  import amxd_pkg::*;
#(
  parameter int NUM_CH = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Device pins
  input wire logic convert_start,
  input wire logic serial_clk,
  input wire logic serial_din,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata,
  // Per-conversion decode
  output logic conv_begin,
  output logic [2:0] pair_positive_input,
  output logic [2:0] pair_negative_input,
  output amxd_neg_t conv_neg_src,
  output logic conv_twos_comp,
  output logic conv_quarter_bw
);
  amxd_cfg_if cfg_if ();
  logic [2:0] pin_s;
  logic cnv_d_r;
  logic [CFG_W-1:0] cfg_r;
  logic seq_en_r;
  logic [2:0] seq_last_r;
  logic [2:0] seq_ch_r;
  logic [GAP_W-1:0] gap_r;
  logic seen_r;
  logic rate_viol_r;

  // Pin synchronisers
  amxd_sync #(
    .W(3)
  ) u_sync (
    .clock(clock),
    .reset(reset),
    .d({~convert_start, serial_clk, serial_din}),
    .q(pin_s)
  );

  // Inverted through the flops so the idle-high pin reads high from reset
  assign cfg_if.cnv_s = ~pin_s[2];
  assign cfg_if.sclk_s = pin_s[1];
  assign cfg_if.din_s = pin_s[0];

  amxd_cfg_shift u_shift (
    .clock(clock),
    .reset(reset),
    .cfg(cfg_if.shifter)
  );

  // Field decode
  wire cnv_rise = cfg_if.cnv_s & ~cnv_d_r;
  wire [2:0] incc = cfg_r[INCC_MSB:INCC_LSB];
  wire [2:0] chsel = cfg_r[CHSEL_MSB:CHSEL_LSB];
  wire bw_quarter = cfg_r[BW_BIT] != BW_FULL;
  wire is_pair = ~incc[1];
  wire is_com = (incc == INCC_COM_UNI) | (incc == INCC_COM_BIP);
  wire is_bip = ~incc[2] & (is_pair | (incc == INCC_COM_BIP));
  wire seq_on = seq_en_r;
  wire [2:0] seq_even = {seq_ch_r[2:1], 1'h0};
  wire [2:0] free_pos = seq_on ? seq_ch_r : chsel;
  wire [2:0] pos_idx = (seq_on & is_pair) ? seq_even : free_pos;
  wire [2:0] neg_idx = is_pair ? (pos_idx ^ 3'h1) : pos_idx;
  wire [2:0] seq_step = is_pair ? 3'h2 : 3'h1;
  wire seq_wrap = seq_ch_r >= seq_last_r;
  wire [2:0] seq_nxt = seq_wrap ? 3'h0 : 3'(seq_ch_r + seq_step);
  wire too_fast = bw_quarter & seen_r & (gap_r < GAP_W'(QBW_CYC));

  amxd_neg_t neg_nxt;
  assign neg_nxt = is_pair ? NEG_PAIR : (is_com ? NEG_COM : NEG_GND);

  // Register decode
  wire wr_ctrl = reg_we & (reg_addr == REG_CTRL);
  wire wr_cfg = reg_we & (reg_addr == REG_CFG);
  wire wr_stat = reg_we & (reg_addr == REG_STAT);
  wire rate_clr = wr_stat & reg_wdata[ST_RATE];
  wire [31:0] ctrl_rd = {28'h0, seq_last_r, seq_en_r};
  wire [31:0] cfg_rd = {18'h0, cfg_r};
  wire [31:0] stat_rd = {21'h0, rate_viol_r, conv_quarter_bw, conv_twos_comp,
                         conv_neg_src, pair_negative_input, pair_positive_input};
  wire [31:0] rd_sel = (reg_addr == REG_CTRL) ? ctrl_rd :
                       (reg_addr == REG_CFG) ? cfg_rd :
                       (reg_addr == REG_STAT) ? stat_rd : 32'h0;

  // Configuration and control registers
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      cfg_r <= CFG_RST;
      seq_en_r <= CTRL_RST[CTL_SEQ_EN];
      seq_last_r <= CTRL_RST[CTL_LAST_LSB+:3];
    end
    else
    begin
      if (cfg_if.word_valid)
        cfg_r <= cfg_if.word;
      else if (wr_cfg)
        cfg_r <= reg_wdata[CFG_W-1:0];
      if (wr_ctrl)
      begin
        seq_en_r <= reg_wdata[CTL_SEQ_EN];
        seq_last_r <= reg_wdata[CTL_LAST_LSB+:3];
      end
    end
  end

  // Sequencer position
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      seq_ch_r <= 3'h0;
    else if (!seq_en_r)
      seq_ch_r <= 3'h0;
    else if (cnv_rise)
      seq_ch_r <= seq_nxt;
  end

  // Conversion start and latched decode
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      cnv_d_r <= 1'h1;
      conv_begin <= 1'h0;
      pair_positive_input <= 3'h0;
      pair_negative_input <= 3'h0;
      conv_neg_src <= NEG_GND;
      conv_twos_comp <= 1'h0;
      conv_quarter_bw <= 1'h0;
    end
    else
    begin
      cnv_d_r <= cfg_if.cnv_s;
      conv_begin <= cnv_rise;
      if (cnv_rise)
      begin
        pair_positive_input <= pos_idx;
        pair_negative_input <= neg_idx;
        conv_neg_src <= neg_nxt;
        conv_twos_comp <= is_bip;
        conv_quarter_bw <= bw_quarter;
      end
    end
  end

  // Conversion spacing watch for quarter bandwidth
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      gap_r <= '0;
      seen_r <= 1'h0;
      rate_viol_r <= 1'h0;
    end
    else
    begin
      if (cnv_rise)
        gap_r <= GAP_W'(1);
      else if (gap_r != '1)
        gap_r <= gap_r + GAP_W'(1);
      if (cnv_rise)
        seen_r <= 1'h1;
      // Set wins over clear
      if (cnv_rise & too_fast)
        rate_viol_r <= 1'h1;
      else if (rate_clr)
        rate_viol_r <= 1'h0;
    end
  end

  // Read data one cycle after the strobe
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      reg_rdata <= 32'h0;
    else if (reg_re)
      reg_rdata <= rd_sel;
    else
      reg_rdata <= 32'h0;
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  a_single_ended_gnd: assert property (
    cnv_rise && incc == INCC_SE |=> conv_neg_src == NEG_GND && !conv_twos_comp)
    else $error("single-ended decode wrong");

  a_com_bipolar_mid: assert property (
    cnv_rise && incc == INCC_COM_BIP |=> conv_neg_src == NEG_COM && conv_twos_comp)
    else $error("common bipolar decode wrong");

  a_com_unipolar_gnd: assert property (
    cnv_rise && incc == INCC_COM_UNI |=> conv_neg_src == NEG_COM && !conv_twos_comp)
    else $error("common unipolar decode wrong");

  a_pair_bipolar_mode: assert property (
    cnv_rise && incc[2:1] == 2'h0 |=> conv_neg_src == NEG_PAIR && conv_twos_comp
      && pair_negative_input == (pair_positive_input ^ 3'h1))
    else $error("bipolar pair decode wrong");

  a_pair_unipolar_mode: assert property (
    cnv_rise && incc[2:1] == 2'h2 |=> conv_neg_src == NEG_PAIR && !conv_twos_comp)
    else $error("unipolar pair decode wrong");

  a_pair_parity_follow: assert property (
    cnv_rise && is_pair && !seq_on |=> pair_positive_input[0] == $past(chsel[0]))
    else $error("pair parity wrong");

  a_chan_direct_select: assert property (
    cnv_rise && !seq_on ##1 conv_neg_src == NEG_PAIR
      |-> pair_positive_input == $past(chsel, 1))
    else $error("positive channel not as selected");

  a_seq_even_positive: assert property (
    cnv_rise && is_pair && seq_on |=> !pair_positive_input[0])
    else $error("sequencer pair not even");

  a_bw_select_latch: assert property (
    cnv_rise |=> conv_quarter_bw == $past(bw_quarter) && conv_begin)
    else $error("bandwidth choice not taken");

  a_rate_flag_set: assert property (
    cnv_rise && too_fast |=> rate_viol_r)
    else $error("fast conversion not flagged");

  a_coding_match: assert property (
    conv_begin |-> conv_twos_comp == (!$past(incc[2]) && $past(incc) != 3'h3))
    else $error("output coding mismatch");

  a_conv_start_edge: assert property (
    $rose(cfg_if.cnv_s) |=> conv_begin ##1 !conv_begin)
    else $error("conversion start not one pulse");

  a_cfg_word_load: assert property (
    cfg_if.word_valid |=> cfg_r == $past(cfg_if.word))
    else $error("captured word not loaded");

  a_decode_steady: assert property (
    !cnv_rise |=> $stable(pair_positive_input) && $stable(conv_neg_src))
    else $error("decode changed without conversion");

  a_decode_rest_steady: assert property (
    !cnv_rise |=> $stable(conv_twos_comp) && $stable(conv_quarter_bw)
      && $stable(pair_negative_input))
    else $error("coding or bandwidth changed without conversion");

  a_neg_equals_pos: assert property (
    conv_begin && conv_neg_src != NEG_PAIR |-> pair_negative_input == pair_positive_input)
    else $error("non-pair negative index differs");

  a_pair_partner_adj: assert property (
    conv_begin && conv_neg_src == NEG_PAIR |-> pair_negative_input == (pair_positive_input ^ 3'h1))
    else $error("pair partner not adjacent");

  a_pulse_one_cycle: assert property (
    conv_begin |=> !conv_begin)
    else $error("conversion start longer than one cycle");

  a_begin_needs_rise: assert property (
    conv_begin |-> $past(cnv_rise))
    else $error("conversion start without convert edge");

  a_word_valid_pulse: assert property (
    cfg_if.word_valid |=> !cfg_if.word_valid)
    else $error("word valid longer than one cycle");

  a_frame_count_cap: assert property (
    u_shift.cnt_r <= 4'(CFG_W))
    else $error("serial bit count beyond word");

  a_serial_wins_write: assert property (
    wr_cfg && cfg_if.word_valid |=> cfg_r == $past(cfg_if.word))
    else $error("register write beat serial word");

  a_cfg_write_load: assert property (
    wr_cfg && !cfg_if.word_valid |=> cfg_r == $past(reg_wdata[CFG_W-1:0]))
    else $error("configuration write not loaded");

  a_seq_hold_off: assert property (
    !seq_en_r |=> seq_ch_r == 3'h0)
    else $error("sequencer moved while off");

  a_seq_wrap_zero: assert property (
    seq_en_r && cnv_rise && seq_wrap |=> seq_ch_r == 3'h0)
    else $error("sequencer did not wrap");

  a_seq_step_pair: assert property (
    seq_en_r && cnv_rise && !seq_wrap && is_pair |=> seq_ch_r == $past(seq_ch_r) + 3'h2)
    else $error("sequencer pair step wrong");

  a_rate_clear_w1c: assert property (
    rate_clr && !(cnv_rise && too_fast) |=> !rate_viol_r)
    else $error("rate flag not cleared");

  a_rate_flag_hold: assert property (
    !cnv_rise && !rate_clr |=> rate_viol_r == $past(rate_viol_r))
    else $error("rate flag changed by itself");

  a_rate_quarter_only: assert property (
    $rose(rate_viol_r) |-> $past(bw_quarter && cnv_rise))
    else $error("rate flag set outside quarter bandwidth");

  a_stat_read_back: assert property (
    $past(reg_re) && $past(reg_addr) == REG_STAT
      |-> reg_rdata[2:0] == $past(pair_positive_input))
    else $error("status read wrong");

  a_rdata_idle_zero: assert property (
    !$past(reg_re) |-> reg_rdata == 32'h0)
    else $error("read data outside read cycle");

  c_pair_odd: cover property (cnv_rise && is_pair && chsel[0] && !seq_on);
  c_seq_wrap: cover property (cnv_rise && seq_on && seq_wrap);
  c_rate_viol: cover property (cnv_rise && too_fast);
  c_cfg_loaded: cover property (cfg_if.word_valid ##[1:40] cnv_rise);
  c_rate_cleared: cover property (rate_clr && rate_viol_r);
endmodule : amxd_decode

// >>> rtl/amxd_sync.sv
/*
  Two flip-flop synchroniser, one per bit.
  Assumes inputs are asynchronous to clock.
*/
`timescale 1ns/1ps
module amxd_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      meta_r <= '0;
      q <= '0;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : amxd_sync

// >>> tb/adc_input_mux_config_decode_bench.sv
/*
  Self-checking bench of the input mux configuration decoder.
  Assumes the host model drives the pins and the bench the register port.
*/
`timescale 1ns/1ps
module adc_input_mux_config_decode_bench;
  import amxd_pkg::*;
  logic clock, reset, reg_we, reg_re, conv_begin, conv_twos_comp, conv_quarter_bw;
  logic convert_start, serial_clk, serial_din;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd;
  logic [2:0] pair_positive_input, pair_negative_input;
  amxd_neg_t conv_neg_src;
  logic [13:0] cases [7] = '{14'h1DC0, 14'h0B40, 14'h1880, 14'h0040, 14'h06C0,
    14'h1100, 14'h17C0};
  int failures = 0;
  int n_tests = 0;

  amxd_decode u_dut (.clock(clock), .reset(reset), .convert_start(convert_start),
    .serial_clk(serial_clk), .serial_din(serial_din), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .conv_begin(conv_begin), .pair_positive_input(pair_positive_input),
    .pair_negative_input(pair_negative_input), .conv_neg_src(conv_neg_src),
    .conv_twos_comp(conv_twos_comp), .conv_quarter_bw(conv_quarter_bw));
  amxd_host_model u_host (.clock(clock), .convert_start(convert_start),
    .serial_clk(serial_clk), .serial_din(serial_din));

  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic check_val(input string name, input logic [31:0] exp,
    input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : check_val

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clock);
    reg_we <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clock);
    reg_re <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : reg_read

  // Packed as the status layout: quarter, twos, source, negative, positive
  function automatic logic [9:0] expect_dec(input logic [13:0] w);
    logic [2:0] m;
    logic [2:0] c;
    logic pair;
    logic twos;
    amxd_neg_t src;
    m = w[12:10];
    c = w[9:7];
    pair = (m[2:1] == 2'b00) || (m[2:1] == 2'b10);
    twos = (m == 3'h2) || (m[2:1] == 2'b00);
    src = pair ? NEG_PAIR : ((m[1:0] == 2'b10) ? NEG_COM : NEG_GND);
    return {~w[6], twos, src, pair ? (c ^ 3'h1) : c, c};
  endfunction : expect_dec

  task automatic run_conv(input logic [9:0] e, input logic [9:0] mask, input int gap);
    int k;
    k = 0;
    u_host.convert();
    while (conv_begin !== 1'b1 && k < 8)
    begin
      @(posedge clock);
      #1;
      k++;
    end
    check_val("conv_begin", 1, conv_begin);
    check_val("decode", e & mask, mask & {conv_quarter_bw, conv_twos_comp,
      conv_neg_src, pair_negative_input, pair_positive_input});
    @(posedge clock);
    #1;
    check_val("conv_pulse", 0, conv_begin);
    u_host.rest(gap);
  endtask : run_conv

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  initial
  begin
    #200000;
    failures++;
    $display("watchdog expired");
    finish_test();
  end

  initial
  begin
    reset = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_we = 1'b0;
    reg_re = 1'b0;
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    reg_read(REG_CFG, rd);
    check_val("cfg_reset", 32'h0000_1C40, rd);
    reg_read(REG_CTRL, rd);
    check_val("ctrl_reset", 32'h0000_000E, rd);
    reg_write(4'hC, 32'hFFFF_FFFF);
    reg_read(4'hC, rd);
    check_val("unmapped", 32'h0, rd);
    $display("test reset done");
    foreach (cases[i])
    begin
      u_host.send_word(cases[i]);
      reg_read(REG_CFG, rd);
      check_val("cfg_word", {18'h0, cases[i]}, rd);
      run_conv(expect_dec(cases[i]), 10'h3FF, 40);
      reg_read(REG_STAT, rd);
      check_val("status", {22'h0, expect_dec(cases[i])}, {22'h0, rd[9:0]});
    end
    $display("test decode table done");
    reg_write(REG_CTRL, 32'h0000_000F);
    reg_write(REG_CFG, 32'h0000_06C0);
    repeat (4) run_conv({2'b01, NEG_PAIR, 3'b001, 3'b000}, 10'h3C9, 20);
    reg_write(REG_CTRL, 32'h0000_000E);
    $display("test sequencer done");
    reg_write(REG_CFG, 32'h0000_1100);
    run_conv(expect_dec(14'h1100), 10'h3FF, 4100);
    reg_write(REG_STAT, 32'h0000_0400);
    run_conv(expect_dec(14'h1100), 10'h3FF, 40);
    reg_read(REG_STAT, rd);
    check_val("rate_slow", 0, rd[10]);
    run_conv(expect_dec(14'h1100), 10'h3FF, 40);
    reg_read(REG_STAT, rd);
    check_val("rate_fast", 1, rd[10]);
    $display("test rate done");
    finish_test();
  end
endmodule : adc_input_mux_config_decode_bench

// >>> tb/amxd_host_model.sv
/*
  Host model: shifts configuration words in and raises convert_start.
  Assumes it shares the clock of the decoder under test.
*/
`timescale 1ns/1ps
module amxd_host_model
  import amxd_pkg::*;
(
  // Clock
  input wire logic clock,
  // Pins toward the device
  output logic convert_start,
  output logic serial_clk,
  output logic serial_din
);
  initial
  begin
    convert_start = 1'b1;
    serial_clk = 1'b0;
    serial_din = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clock);
  endtask : hold
  // MSB first, 4-cycle clock halves, serial clock still outside frames
  task automatic send_word(input logic [CFG_W-1:0] w);
    convert_start <= 1'b0;
    hold(4);
    for (int i = CFG_W - 1; i >= 0; i--)
    begin
      serial_din <= w[i];
      hold(4);
      serial_clk <= 1'b1;
      hold(4);
      serial_clk <= 1'b0;
    end
    hold(1);
    serial_din <= ~w[0];
    hold(8);
  endtask : send_word
  // Rising edge ends acquisition
  task automatic convert();
    hold(1);
    convert_start <= 1'b1;
  endtask : convert
  // Caller's gap sets the conversion rate
  task automatic rest(input int gap);
    hold(1);
    convert_start <= 1'b0;
    hold(gap);
  endtask : rest
endmodule : amxd_host_model
